// *** rtl/input_change_interrupt_status.sv ***
// Latched input-change interrupt status with AXI4-Lite register access
//
// Summary of operation
// - Low byte bits 7..0 latch validity changes of references eight down to one.
// - Status bits stay set until software writes one to that bit.
// - A zero bit means no event since that bit was last cleared.
// - Mid byte bit 7 sets whenever the operating mode changes.
// - Mid byte bit 6 sets after two missing main-path cycles, not in free-run/holdover.
// - Low byte resets to all ones.
// - Mid byte resets to 0x3F: two upper bits clear, six lower set.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module input_change_interrupt_status
	import input_change_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [13:0] ref_valid,
	input wire logic [1:0] op_mode,
	input wire logic main_ref_clk,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);

	// ----------------------------------------------------------------
	// Input synchronisers (three stages, change on agreement)
	// ----------------------------------------------------------------
	logic [13:0] valid_s1, valid_s2, valid_s3, valid_seen;
	logic [1:0] mode_s1, mode_s2, mode_s3, mode_seen;
	logic clk_s1, clk_s2, clk_s3, clk_seen;

	// Reference validity chain
	always_ff @(posedge core_clk) begin
		valid_s1 <= ref_valid;
		valid_s2 <= valid_s1;
		valid_s3 <= valid_s2;
	end

	// Operating mode chain
	always_ff @(posedge core_clk) begin
		mode_s1 <= op_mode;
		mode_s2 <= mode_s1;
		mode_s3 <= mode_s2;
	end

	// Main reference clock chain
	always_ff @(posedge core_clk) begin
		clk_s1 <= main_ref_clk;
		clk_s2 <= clk_s1;
		clk_s3 <= clk_s2;
	end

	wire [13:0] valid_agree = ~(valid_s2 ^ valid_s3);
	wire [13:0] next_valid_seen = (valid_s2 & valid_agree) | (valid_seen & ~valid_agree);
	wire mode_agree = (mode_s2 == mode_s3);
	wire [1:0] next_mode_seen = mode_agree ? mode_s2 : mode_seen;
	wire clk_agree = (clk_s2 == clk_s3);
	wire next_clk_seen = clk_agree ? clk_s2 : clk_seen;

	// Settled-state trackers; primed flag suppresses false events after reset
	logic primed;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			valid_seen <= '0;
		end else begin
			valid_seen <= next_valid_seen;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_seen <= 2'h0;
		end else begin
			mode_seen <= next_mode_seen;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			clk_seen <= 1'b0;
		end else begin
			clk_seen <= next_clk_seen;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			primed <= 1'b0;
		end else begin
			primed <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	wire [13:0] ref_change = primed ? (next_valid_seen ^ valid_seen) : '0;
	wire mode_change = primed && (next_mode_seen != mode_seen);
	wire main_edge = next_clk_seen & ~clk_seen;

	// Missing-cycle watchdog on the main path: a reference period is many
	// core cycles, so gap is measured as elapsed time since the last edge.
	localparam int gap_bits = 16;
	parameter logic [gap_bits-1:0] ref_period_cycles = 16'h0010;
	logic [gap_bits-1:0] gap_count;
	logic [1:0] missed;
	logic main_fail_armed;
	wire tracking = (mode_seen == 2'(mode_locked));
	wire period_elapsed = (gap_count == ref_period_cycles);
	wire [1:0] next_missed = main_edge ? 2'h0 :
		(period_elapsed && missed != 2'(missing_cycles_limit)) ? missed + 2'h1 : missed;
	wire main_fail = tracking && main_fail_armed &&
		(next_missed == 2'(missing_cycles_limit)) && (missed != 2'(missing_cycles_limit));

	wire [gap_bits-1:0] next_gap_count = (main_edge || period_elapsed) ? '0 : gap_count + 1'b1;

	// Time since the last main-path edge or the last elapsed reference period, restarting at one reference period
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			gap_count <= '0;
		end else begin
			gap_count <= next_gap_count;
		end
	end

	// Missing periods count only while locked; other modes start afresh
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			missed <= 2'h0;
		end else begin
			missed <= tracking ? next_missed : 2'h0;
		end
	end

	// Holds off a failure verdict on the first locked cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			main_fail_armed <= 1'b0;
		end else begin
			main_fail_armed <= tracking;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire have_aw = aw_held || aw_take;
	wire have_w = w_held || w_take;
	wire do_write = have_aw && have_w && !s_axi_bvalid;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == flags_low_addr) || (a == flags_mid_addr) ||
			(a == irq_status_addr) || (a == irq_clear_addr) ||
			(a == irq_enable_addr) || (a == live_state_addr);
	endfunction

	wire lane0 = wr_strb[0];
	wire wr_low = do_write && lane0 && (wr_addr == flags_low_addr);
	wire wr_mid = do_write && lane0 && (wr_addr == flags_mid_addr);
	wire wr_clr = do_write && lane0 && (wr_addr == irq_clear_addr);
	wire wr_en = do_write && lane0 && (wr_addr == irq_enable_addr);

	wire next_awready = !have_aw && !s_axi_bvalid && !s_axi_awready;
	wire next_wready = !have_w && !s_axi_bvalid && !s_axi_wready;
	wire [1:0] write_resp = known_addr(wr_addr) ? resp_okay : resp_slverr;

	// Address and data parked until both halves of the write are in
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (aw_take) aw_addr <= s_axi_awaddr;
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			aw_held <= have_aw && !do_write;
			w_held <= have_w && !do_write;
		end
	end

	// Ready pulses one cycle and stays low while a response waits
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
		end
	end

	// Response holds until the master takes it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_resp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Latched status flags
	// ----------------------------------------------------------------
	logic [7:0] flags_low;
	logic [7:0] flags_mid;
	wire [7:0] clr_low = wr_low ? wr_data[7:0] : 8'h00;
	wire [7:0] clr_mid = wr_mid ? wr_data[7:0] : 8'h00;
	wire [7:0] set_low = ref_change[low_refs-1:0];
	wire [7:0] set_mid = {mode_change, main_fail, ref_change[num_refs-1:low_refs]};

	// Set wins over a simultaneous clear
	wire [7:0] next_flags_low = set_low | (flags_low & ~clr_low);
	wire [7:0] next_flags_mid = set_mid | (flags_mid & ~clr_mid);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flags_low <= flags_low_reset;
		end else begin
			flags_low <= next_flags_low;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flags_mid <= flags_mid_reset;
		end else begin
			flags_mid <= next_flags_mid;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt summary: status, clear, enable
	// ----------------------------------------------------------------
	logic [2:0] irq_status;
	logic [2:0] irq_enable;
	wire [2:0] irq_event;
	assign irq_event[irq_low_bit] = |set_low;
	assign irq_event[irq_mid_bit] = |set_mid[main_fail_bit-1:0] | set_mid[mode_change_bit];
	assign irq_event[irq_main_bit] = set_mid[main_fail_bit];
	wire [2:0] irq_clr = wr_clr ? wr_data[2:0] : 3'h0;
	wire [2:0] next_irq_status = irq_event | (irq_status & ~irq_clr);

	wire [2:0] next_irq_enable = wr_en ? wr_data[2:0] : irq_enable;
	wire next_irq = |(next_irq_status & next_irq_enable);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_enable <= irq_enable_reset;
		end else begin
			irq_enable <= next_irq_enable;
		end
	end

	// Registered pin follows status and mask of the same edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire [31:0] rd_word =
		(s_axi_araddr == flags_low_addr) ? {24'h000000, flags_low} :
		(s_axi_araddr == flags_mid_addr) ? {24'h000000, flags_mid} :
		(s_axi_araddr == irq_status_addr) ? {29'h0, irq_status} :
		(s_axi_araddr == irq_enable_addr) ? {29'h0, irq_enable} :
		(s_axi_araddr == live_state_addr) ? {16'h0000, mode_seen, valid_seen} :
		32'h0000_0000;

	wire next_arready = !s_axi_rvalid && !s_axi_arready;
	wire [1:0] read_resp = known_addr(s_axi_araddr) ? resp_okay : resp_slverr;

	// Address ready pulses one cycle, never while data waits
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= next_arready;
		end
	end

	// Read data holds until the master takes it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= read_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // input_change_interrupt_status

// *** inc/input_change_pkg.sv ***
// Package: register map, reset values and field layout for the input change status block
package input_change_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] flags_low_addr = 8'h00;
	localparam logic [7:0] flags_mid_addr = 8'h04;
	localparam logic [7:0] irq_status_addr = 8'h08;
	localparam logic [7:0] irq_clear_addr = 8'h0C;
	localparam logic [7:0] irq_enable_addr = 8'h10;
	localparam logic [7:0] live_state_addr = 8'h14;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int num_refs = 14;
	localparam int low_refs = 8;
	localparam logic [7:0] flags_low_reset = 8'hFF;
	localparam logic [7:0] flags_mid_reset = 8'h3F;
	localparam int mode_change_bit = 7;
	localparam int main_fail_bit = 6;
	localparam logic [2:0] irq_enable_reset = 3'h0;
	localparam int missing_cycles_limit = 2;

	// Interrupt event positions
	localparam int irq_low_bit = 0;
	localparam int irq_mid_bit = 1;
	localparam int irq_main_bit = 2;

	// AXI responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Operating modes
	typedef enum logic [1:0] {
		mode_free_run,
		mode_locked,
		mode_holdover
	} op_mode_e;

endpackage

// *** test/input_change_chk.sv ***
// Handshake and reset checks at the ports of the input change status block
`timescale 1ns/1ps

module input_change_chk
	import input_change_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write response late");
	a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_no_new_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_no_new_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == resp_slverr |-> s_axi_rdata == 32'h0)
		else $error("error read with nonzero data");
	a_reset_idle: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !s_axi_arready)
		else $error("outputs busy right after reset");
endmodule // input_change_chk

// *** test/tb_top.sv ***
// Register-level testbench for the input change status block
`timescale 1ns/1ps

module tb_top
	import input_change_pkg::*;
;
	logic core_clk, rst_n, main_ref_clk, mrun, mphase, irq;
	logic [13:0] ref_valid;
	logic [1:0] op_mode, bresp, rresp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int failures, checks;

	input_change_interrupt_status #(.ref_period_cycles(16'h0004)) DUT (.core_clk(core_clk),
		.rst_n(rst_n), .ref_valid(ref_valid), .op_mode(op_mode), .main_ref_clk(main_ref_clk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Main reference: four core cycles per period while enabled, each level
	// held two samples so the synchroniser sees it
	always @(posedge core_clk) begin
		mphase <= ~mphase;
		if (mrun && mphase) main_ref_clk <= ~main_ref_clk;
	end

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50) failures++;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a; arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		d = rdata;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(n, d, exp);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#200000;
		failures++;
		summarize();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		failures = 0; checks = 0; rst_n = 1'b0; mrun = 1'b0; main_ref_clk = 1'b0; mphase = 1'b0;
		ref_valid = 14'h3FFF; op_mode = 2'h0; wstrb = 4'hF; bready = 1'b1; rready = 1'b1;
		awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
		wt(6);
		rst_n <= 1'b1;
		wt(10);
		rc("low reset", flags_low_addr, 32'h0000_00FF);
		rc("mid reset", flags_mid_addr, 32'h0000_003F);
		wr(flags_low_addr, 32'hFF);
		chk("write resp", {30'h0, bresp}, {30'h0, resp_okay});
		wr(flags_mid_addr, 32'hFF);
		rc("low cleared", flags_low_addr, 32'h0);
		rc("mid cleared", flags_mid_addr, 32'h0);
		$display("test reset and clear done");
		ref_valid <= 14'h3F7E;
		wt(10);
		rc("low events", flags_low_addr, 32'h81);
		wr(flags_low_addr, 32'h01);
		rc("low one cleared", flags_low_addr, 32'h80);
		wstrb <= 4'h0;
		wr(flags_low_addr, 32'hFF);
		wstrb <= 4'hF;
		rc("low strobe off", flags_low_addr, 32'h80);
		ref_valid <= 14'h1E7E;
		wt(10);
		rc("mid events", flags_mid_addr, 32'h21);
		wr(flags_mid_addr, 32'h21);
		rc("mid quiet", flags_mid_addr, 32'h0);
		$display("test input changes done");
		mrun <= 1'b1;
		wt(10);
		op_mode <= 2'h1;
		wt(10);
		rc("mode change", flags_mid_addr, 32'h80);
		wr(flags_mid_addr, 32'hFF);
		mrun <= 1'b0;
		wt(30);
		rc("main fail", flags_mid_addr, 32'h40);
		op_mode <= 2'h2;
		wt(10);
		wr(flags_mid_addr, 32'hFF);
		wt(30);
		rc("holdover silent", flags_mid_addr, 32'h0);
		$display("test mode and main path done");
		wr(irq_clear_addr, 32'h7);
		wr(irq_enable_addr, 32'h1);
		rc("irq enable", irq_enable_addr, 32'h1);
		ref_valid <= 14'h1E7C;
		wt(10);
		rc("irq status", irq_status_addr, 32'h1);
		chk("irq set", {31'h0, irq}, 32'h1);
		wr(irq_enable_addr, 32'h0);
		wt(3);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(irq_enable_addr, 32'h1);
		wt(3);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(irq_clear_addr, 32'h7);
		wt(3);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rd(8'h18);
		chk("unmapped data", d, 32'h0);
		chk("unmapped resp", {30'h0, rresp}, {30'h0, resp_slverr});
		wr(8'h18, 32'h0);
		chk("unmapped write resp", {30'h0, bresp}, {30'h0, resp_slverr});
		rc("live state", live_state_addr, 32'h0000_9E7C);
		$display("test interrupt and unmapped done");
		summarize();
	end
endmodule // tb_top

bind input_change_interrupt_status input_change_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq));
